//--- hdl/apcr_pkg.sv
// Purpose: Shared constants for the audio path configuration register pair
// Assumes: Serial frame of one command byte then one 16-bit data word, MSB first
// Notes:   Field positions and reset values used by the core and its checks

package apcr_pkg;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W        = 8;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FRAME_W      = CMD_W + DATA_W;
  localparam logic [4:0]  FRAME_BITS   = 5'h18;
  localparam int unsigned CMD_PU_BIT   = 0;   // chip_power_up
  localparam int unsigned CMD_LD0_BIT  = 1;   // load_first_config
  localparam int unsigned CMD_LD1_BIT  = 2;   // load_second_config

  // ----------------------------------------------------------------
  // Holding/first register fields
  // ----------------------------------------------------------------
  localparam int unsigned F0_ATT_PD    = 0;
  localparam int unsigned F0_SPK_LO    = 1;
  localparam int unsigned F0_OPS_LO    = 3;
  localparam int unsigned F0_AO_PD     = 5;
  localparam int unsigned F0_AOS_LO    = 6;
  localparam int unsigned F0_INS       = 9;
  localparam int unsigned F0_AX_PD     = 10;
  localparam int unsigned F0_AXG_LO    = 11;
  localparam int unsigned F0_AI_PD     = 13;
  localparam int unsigned F0_AIG_LO    = 14;

  // ----------------------------------------------------------------
  // Commit/second register fields
  // ----------------------------------------------------------------
  localparam int unsigned F1_AGC_PD    = 0;
  localparam int unsigned F1_FLT_PD    = 1;
  localparam int unsigned F1_RATE_LO   = 2;
  localparam int unsigned F1_FSRC      = 4;
  localparam int unsigned F1_S2M_LO    = 5;
  localparam int unsigned F1_S1M_LO    = 7;
  localparam int unsigned F1_S1X_LO    = 9;
  localparam int unsigned F1_VOL_LO    = 11;
  localparam int unsigned F1_VLS_LO    = 14;

  // ----------------------------------------------------------------
  // Reset values: every stage powered down
  // ----------------------------------------------------------------
  localparam logic [15:0] FIRST_RST    = 16'h2421;
  localparam logic [15:0] SECOND_RST   = 16'h01E3;

  // ----------------------------------------------------------------
  // Decoded figures
  // ----------------------------------------------------------------
  localparam logic [12:0] RATE_8K0     = 13'h1F40;  // 8000 Hz
  localparam logic [12:0] RATE_6K4     = 13'h1900;  // 6400 Hz
  localparam logic [12:0] RATE_5K3     = 13'h14B4;  // 5300 Hz
  localparam logic [12:0] RATE_4K0     = 13'h0FA0;  // 4000 Hz
  localparam logic [4:0]  ATT_STEP_DB  = 5'h04;
  localparam logic [1:0]  MODE_OFF     = 2'h3;
  localparam logic [1:0]  MUX_UNUSED   = 2'h3;

endpackage

//--- hdl/apcr_top.sv
// Purpose: Serial-loaded audio path configuration pair, double buffered
// Assumes: Host drives sclk/ss_n/mosi, mode 0, holds ss_n low two clk after last sclk
// Notes:   Settings commit in the clk domain at the synchronised rise of ss_n
//
// Operation
// - commit bit 0 powers down gain amp
// - commit bit 1 powers down filter stage
// - bits 3:2 pick sample rate and band
// - bit 4 picks summer or storage source
// - bits 6:5 set second summer mode
// - bits 8:7 set first summer mode
// - bits 10:9 pick first summer mux
// - bits 13:11 give attenuation code times four
// - bits 15:14 pick volume mux source
// - commit load updates live settings at end
// - first load only fills holding register
// - commit load also copies holding into live
// - complete loads accepted while powered down; decoded fields show them only when powered
// - analog out mux zero selects feedthrough
// - first bit 5 powers analog output off
// - bits 15:14 gain, bit 13 power
// - output mux code 01 selects analog input
// - speaker bits 01 give high gain speaker
// - bit 0 attenuator, bit 10 aux power
// - bit 9 source select, 12:11 aux gain
// - two command bits choose load target

`timescale 1ns/1ps

module apcr_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             chip_power_up,
  output logic [15:0]      path_config_commit,
  output logic [15:0]      path_config_first,
  output logic [15:0]      path_config_holding,
  output logic             gain_amp_power_down,
  output logic             filter_power_down,
  output logic [1:0]       rate_select,
  output logic [12:0]      sample_rate_hz,
  output logic             filter_source_select,
  output logic [1:0]       second_summer_mode,
  output logic [1:0]       first_summer_mode,
  output logic [1:0]       first_summer_mux,
  output logic             first_summer_mux_unused,
  output logic [2:0]       attenuation_code,
  output logic [4:0]       attenuation_db,
  output logic [1:0]       volume_source_select,
  output logic [2:0]       analog_out_source,
  output logic             mic_feedthrough_path,
  output logic             analog_out_power_down,
  output logic [1:0]       analog_in_gain,
  output logic             analog_in_power_down,
  output logic [1:0]       output_source_select,
  output logic             output_from_analog_in,
  output logic [1:0]       speaker_aux_control,
  output logic             speaker_high_gain,
  output logic             attenuator_power_down,
  output logic             aux_in_power_down,
  output logic [1:0]       aux_in_gain,
  output logic             input_source_select
);

  import apcr_pkg::*;

  // ----------------------------------------------------------------
  // Link domain: shift in one frame
  // ----------------------------------------------------------------
  logic [4:0]         bit_cnt_q;
  logic [FRAME_W-1:0] frame_q;
  logic               frame_full_q;

  // Bit counter, cleared whenever the frame is closed
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Full flag, stays set until the frame closes
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      frame_full_q <= 1'b0;
    end else if (bit_cnt_q == FRAME_BITS - 5'h01) begin
      frame_full_q <= 1'b1;
    end
  end

  // Shift register, frozen after the last bit so clk side reads it stable
  always_ff @(posedge sclk) begin
    if (bit_cnt_q != FRAME_BITS) begin
      frame_q <= {frame_q[FRAME_W-2:0], mosi};
    end
  end

  // ----------------------------------------------------------------
  // Crossing into clk domain
  // ----------------------------------------------------------------
  logic ss_s1_q, ss_s2_q, ss_s3_q;
  logic full_s1_q, full_s2_q;
  logic pending_q;
  logic commit_evt;

  // Two-stage synchronisers, third stage for the edge detect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_s1_q   <= 1'b1;
      ss_s2_q   <= 1'b1;
      ss_s3_q   <= 1'b1;
      full_s1_q <= 1'b0;
      full_s2_q <= 1'b0;
    end else begin
      ss_s1_q   <= ss_n;
      ss_s2_q   <= ss_s1_q;
      ss_s3_q   <= ss_s2_q;
      full_s1_q <= frame_full_q;
      full_s2_q <= full_s1_q;
    end
  end

  // Complete frame seen; consumed at the close of the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
    end else if (ss_s2_q && !ss_s3_q) begin
      pending_q <= 1'b0;
    end else if (full_s2_q) begin
      pending_q <= 1'b1;
    end
  end

  assign commit_evt = ss_s2_q && !ss_s3_q && (pending_q || full_s2_q);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [CMD_W-1:0]  cmd;
  logic [DATA_W-1:0] data;
  logic              ld_first;
  logic              ld_second;
  logic              pu_q;
  logic [15:0]       holding_q;
  logic [15:0]       first_q;
  logic [15:0]       second_q;

  assign cmd       = frame_q[FRAME_W-1:DATA_W];
  assign data      = frame_q[DATA_W-1:0];
  assign ld_first  = cmd[CMD_LD0_BIT];
  assign ld_second = cmd[CMD_LD1_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pu_q <= 1'b0;
    end else if (commit_evt) begin
      pu_q <= cmd[CMD_PU_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holding_q <= FIRST_RST;
    end else if (commit_evt && ld_first) begin
      holding_q <= data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_q <= FIRST_RST;
    end else if (commit_evt && ld_second) begin
      first_q <= holding_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      second_q <= SECOND_RST;
    end else if (commit_evt && ld_second) begin
      second_q <= data;
    end
  end

  // ----------------------------------------------------------------
  // Decode, seen only while powered up
  // ----------------------------------------------------------------
  logic [15:0] f0, f1;

  assign f0 = pu_q ? first_q  : FIRST_RST;
  assign f1 = pu_q ? second_q : SECOND_RST;

  assign chip_power_up       = pu_q;
  assign path_config_commit  = second_q;
  assign path_config_first   = first_q;
  assign path_config_holding = holding_q;

  assign gain_amp_power_down  = f1[F1_AGC_PD];
  assign filter_power_down    = f1[F1_FLT_PD];
  assign filter_source_select = f1[F1_FSRC];
  assign second_summer_mode   = f1[F1_S2M_LO +: 2];
  assign first_summer_mode    = f1[F1_S1M_LO +: 2];
  assign first_summer_mux        = f1[F1_S1X_LO +: 2];
  assign first_summer_mux_unused = (f1[F1_S1X_LO +: 2] == MUX_UNUSED);
  assign attenuation_code     = f1[F1_VOL_LO +: 3];
  assign attenuation_db       = {2'h0, f1[F1_VOL_LO +: 3]} * ATT_STEP_DB;
  assign volume_source_select = f1[F1_VLS_LO +: 2];
  assign rate_select          = f1[F1_RATE_LO +: 2];

  always_comb begin
    unique case (f1[F1_RATE_LO +: 2])
      2'h0: sample_rate_hz = RATE_8K0;
      2'h1: sample_rate_hz = RATE_6K4;
      2'h2: sample_rate_hz = RATE_5K3;
      2'h3: sample_rate_hz = RATE_4K0;
    endcase
  end

  assign analog_out_source     = f0[F0_AOS_LO +: 3];
  assign mic_feedthrough_path  = (f0[F0_AOS_LO +: 3] == 3'h0);
  assign analog_out_power_down = f0[F0_AO_PD];
  assign analog_in_gain        = f0[F0_AIG_LO +: 2];
  assign analog_in_power_down  = f0[F0_AI_PD];
  assign output_source_select  = f0[F0_OPS_LO +: 2];
  assign output_from_analog_in = (f0[F0_OPS_LO +: 2] == 2'h1);
  assign speaker_aux_control   = f0[F0_SPK_LO +: 2];
  assign speaker_high_gain     = (f0[F0_SPK_LO +: 2] == 2'h1);
  assign attenuator_power_down = f0[F0_ATT_PD];
  assign aux_in_power_down     = f0[F0_AX_PD];
  assign input_source_select   = f0[F0_INS];
  assign aux_in_gain           = f0[F0_AXG_LO +: 2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_second_live;
    @(posedge clk) disable iff (!rst_n)
      (commit_evt && ld_second) |=> (second_q == $past(data));
  endproperty
  a_second_live: assert property (p_second_live)
    else $error("second register did not take frame data");

  property p_second_hold;
    @(posedge clk) disable iff (!rst_n)
      !(commit_evt && ld_second) |=> $stable(second_q) && $stable(first_q);
  endproperty
  a_second_hold: assert property (p_second_hold)
    else $error("live settings changed without commit");

  property p_first_holding;
    @(posedge clk) disable iff (!rst_n)
      (commit_evt && ld_first && !ld_second) |=>
        (holding_q == $past(data)) && $stable(first_q);
  endproperty
  a_first_holding: assert property (p_first_holding)
    else $error("first load touched live settings");

  property p_copy_holding;
    @(posedge clk) disable iff (!rst_n)
      (commit_evt && ld_second) |=> (first_q == $past(holding_q));
  endproperty
  a_copy_holding: assert property (p_copy_holding)
    else $error("holding not copied into live first register");

  property p_hidden;
    @(posedge clk) disable iff (!rst_n)
      !pu_q |-> (gain_amp_power_down && filter_power_down && analog_in_power_down);
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("settings visible while powered down");

  property p_gain_pd;
    @(posedge clk) disable iff (!rst_n)
      pu_q |-> (gain_amp_power_down == second_q[F1_AGC_PD]);
  endproperty
  a_gain_pd: assert property (p_gain_pd)
    else $error("gain amp power bit wrong");

  property p_rate;
    @(posedge clk) disable iff (!rst_n)
      (pu_q && second_q[F1_RATE_LO +: 2] == 2'h2) |-> (sample_rate_hz == RATE_5K3);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate decode wrong");

  property p_atten;
    @(posedge clk) disable iff (!rst_n)
      pu_q |-> (attenuation_db == {second_q[F1_VOL_LO +: 3], 2'h0});
  endproperty
  a_atten: assert property (p_atten)
    else $error("attenuation not four dB per step");

  property p_feed;
    @(posedge clk) disable iff (!rst_n)
      mic_feedthrough_path |-> (analog_out_source == 3'h0);
  endproperty
  a_feed: assert property (p_feed)
    else $error("feedthrough flagged on non-zero source");

  property p_speaker;
    @(posedge clk) disable iff (!rst_n)
      speaker_high_gain |-> (first_q[F0_SPK_LO +: 2] == 2'h1) && pu_q;
  endproperty
  a_speaker: assert property (p_speaker)
    else $error("speaker high gain without code 01");

  c_first_then_second: cover property (@(posedge clk) disable iff (!rst_n)
    (commit_evt && ld_first) ##[1:1000] (commit_evt && ld_second));
  c_powered_commit: cover property (@(posedge clk) disable iff (!rst_n)
    commit_evt && ld_second && cmd[CMD_PU_BIT]);
  c_load_while_down: cover property (@(posedge clk) disable iff (!rst_n)
    commit_evt && ld_second && !cmd[CMD_PU_BIT]);
  c_summers_off: cover property (@(posedge clk) disable iff (!rst_n)
    pu_q && (second_summer_mode == MODE_OFF) && (first_summer_mode == MODE_OFF));

endmodule

//--- sim/apcr_host_model.sv
// Purpose: Host side of the serial configuration link
// Assumes: Mode 0, MSB first, sclk idle low and still outside frames
// Notes:   Released mosi shows the inverse of its last bit, not a held value

`timescale 1ns/1ps

module apcr_host_model (
  output logic sclk,
  output logic ss_n,
  output logic mosi
);
  // Idle link at time zero
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // load bits pick target
  task automatic send(input logic pwr, input logic ld0, input logic ld1,
                      input logic [15:0] data, input int nbits);
    logic [23:0] word;
    word = {5'h00, ld1, ld0, pwr, data};
    ss_n = 1'b0;
    #24;
    for (int i = 0; i < nbits; i++) begin
      mosi = word[23 - i];  // Data set while sclk is low
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    // Select held low past two system clocks, then a long gap
    #100 ss_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule

//--- sim/test_apcr_top.sv
// Purpose: Self-checking bench for the configuration register pair
// Assumes: Host model drives the link at a 48 ns bit period
// Notes:   Each frame is followed by a fixed settle time of five clk before checking

`timescale 1ns/1ps

module test_apcr_top;
  import apcr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, sclk, ss_n, mosi;
  logic        chip_power_up, gain_amp_power_down, filter_power_down;
  logic        filter_source_select, first_summer_mux_unused, mic_feedthrough_path;
  logic        analog_out_power_down, analog_in_power_down, output_from_analog_in;
  logic        speaker_high_gain, attenuator_power_down, aux_in_power_down;
  logic        input_source_select;
  logic [15:0] path_config_commit, path_config_first, path_config_holding;
  logic [1:0]  rate_select, second_summer_mode, first_summer_mode, first_summer_mux;
  logic [1:0]  volume_source_select, analog_in_gain, output_source_select;
  logic [1:0]  speaker_aux_control, aux_in_gain;
  logic [12:0] sample_rate_hz;
  logic [2:0]  attenuation_code, analog_out_source;
  logic [4:0]  attenuation_db;
  int          n_errors, n_compared;
  localparam logic [12:0] RATES [4] = '{RATE_8K0, RATE_6K4, RATE_5K3, RATE_4K0};

  // Design and host
  apcr_top u_apcr_top (.clk, .rst_n, .sclk, .ss_n, .mosi, .chip_power_up,
    .path_config_commit, .path_config_first, .path_config_holding,
    .gain_amp_power_down, .filter_power_down, .rate_select, .sample_rate_hz,
    .filter_source_select, .second_summer_mode, .first_summer_mode,
    .first_summer_mux, .first_summer_mux_unused, .attenuation_code,
    .attenuation_db, .volume_source_select, .analog_out_source,
    .mic_feedthrough_path, .analog_out_power_down, .analog_in_gain,
    .analog_in_power_down, .output_source_select, .output_from_analog_in,
    .speaker_aux_control, .speaker_high_gain, .attenuator_power_down,
    .aux_in_power_down, .aux_in_gain, .input_source_select);
  apcr_host_model u_apcr_host_model (.sclk, .ss_n, .mosi);

  // System clock, 50 ns
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic pwr, input logic ld0, input logic ld1,
                       input logic [15:0] d, input int n);
    u_apcr_host_model.send(pwr, ld0, ld1, d, n);
    repeat (5) @(posedge clk);
    #2;
  endtask

  task automatic check_first(input logic [15:0] v);
    cmp(16'(attenuator_power_down), 16'(v[0]));
    cmp(16'(speaker_aux_control), 16'(v[2:1]));
    cmp(16'(speaker_high_gain), 16'(v[2:1] == 2'h1));
    cmp(16'(output_source_select), 16'(v[4:3]));
    cmp(16'(output_from_analog_in), 16'(v[4:3] == 2'h1));
    cmp(16'(analog_out_power_down), 16'(v[5]));
    cmp(16'(analog_out_source), 16'(v[8:6]));
    cmp(16'(mic_feedthrough_path), 16'(v[8:6] == 3'h0));
    cmp(16'(input_source_select), 16'(v[9]));
    cmp(16'(aux_in_power_down), 16'(v[10]));
    cmp(16'(aux_in_gain), 16'(v[12:11]));
    cmp(16'(analog_in_power_down), 16'(v[13]));
    cmp(16'(analog_in_gain), 16'(v[15:14]));
  endtask

  task automatic check_second(input logic [15:0] v);
    cmp(16'(gain_amp_power_down), 16'(v[0]));
    cmp(16'(filter_power_down), 16'(v[1]));
    cmp(16'(rate_select), 16'(v[3:2]));
    cmp(16'(sample_rate_hz), 16'(RATES[v[3:2]]));
    cmp(16'(filter_source_select), 16'(v[4]));
    cmp(16'(second_summer_mode), 16'(v[6:5]));
    cmp(16'(first_summer_mode), 16'(v[8:7]));
    cmp(16'(first_summer_mux), 16'(v[10:9]));
    cmp(16'(first_summer_mux_unused), 16'(v[10:9] == 2'h3));
    cmp(16'(attenuation_code), 16'(v[13:11]));
    cmp(16'(attenuation_db), 16'({v[13:11], 2'h0}));
    cmp(16'(volume_source_select), 16'(v[15:14]));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    cmp(16'(chip_power_up), 16'h0000);
    cmp(path_config_holding, FIRST_RST);
    cmp(path_config_first, FIRST_RST);
    cmp(path_config_commit, SECOND_RST);
    check_first(FIRST_RST);
    check_second(SECOND_RST);
    $display("test reset done");
  endtask

  // Loads land while powered down but stay hidden until power-up
  task automatic test_power_gate();
    frame(1'b0, 1'b0, 1'b1, 16'h00C5, 24);
    cmp(16'(chip_power_up), 16'h0000);
    cmp(path_config_commit, 16'h00C5);
    check_second(SECOND_RST);
    frame(1'b1, 1'b0, 1'b0, 16'hFFFF, 24);
    cmp(16'(chip_power_up), 16'h0001);
    cmp(path_config_commit, 16'h00C5);
    cmp(path_config_holding, FIRST_RST);
    check_second(16'h00C5);
    check_first(FIRST_RST);
    $display("test power gate done");
  endtask

  // Every code of every second-register field
  task automatic test_second_fields();
    logic [2:0]  i;
    logic [15:0] d;
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      d = {i[1:0], i, i[2:1], ~i[1:0], i[1], i[2], i[0], i[1:0], ~i[0], i[2]};
      frame(1'b1, 1'b0, 1'b1, d, 24);
      cmp(path_config_commit, d);
      check_second(d);
    end
    $display("test second fields done");
  endtask

  // First load waits in holding until the next second load
  task automatic test_first_commit();
    logic [15:0] vals [3];
    logic [15:0] live;
    vals = '{16'h440B, 16'hA5D6, 16'h5A29};
    live = FIRST_RST;
    foreach (vals[k]) begin
      frame(1'b1, 1'b1, 1'b0, vals[k], 24);
      cmp(path_config_holding, vals[k]);
      cmp(path_config_first, live);
      check_first(live);
      frame(1'b1, 1'b0, 1'b1, 16'h01E3, 24);
      cmp(path_config_first, vals[k]);
      check_first(vals[k]);
      live = vals[k];
    end
    $display("test first commit done");
  endtask

  // Both load bits at once, then a short frame that must be dropped
  task automatic test_both_and_short();
    frame(1'b1, 1'b1, 1'b1, 16'h1234, 24);
    cmp(path_config_holding, 16'h1234);
    cmp(path_config_commit, 16'h1234);
    cmp(path_config_first, 16'h5A29);
    frame(1'b1, 1'b0, 1'b1, 16'h0148, 24);
    cmp(path_config_first, 16'h1234);
    frame(1'b1, 1'b1, 1'b1, 16'hFFFF, 23);
    cmp(path_config_commit, 16'h0148);
    cmp(path_config_holding, 16'h1234);
    $display("test both and short done");
  endtask

  // Reset in mid-run brings back the powered-down settings, then a load works again
  task automatic test_mid_reset();
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    test_reset();
    frame(1'b1, 1'b0, 1'b1, 16'h0148, 24);
    cmp(16'(chip_power_up), 16'h0001);
    check_second(16'h0148);
    check_first(FIRST_RST);
    $display("test mid reset done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #1000000;
    n_errors++;
    $display("[ERR] %0t run exceeded its time limit", $time);
    print_verdict();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    test_reset();
    test_power_gate();
    test_second_fields();
    test_first_commit();
    test_both_and_short();
    test_mid_reset();
    print_verdict();
  end
endmodule
